// ===== design/ecms_top.sv
/*
 Clock source selection and machine cycle generation.
 Assumes the input clock pins are sampled by clk (50 MHz), are slower than
 half of it, and that the straps are static from power-up.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ecms_consts.svh"
module ecms_top
   import ecms_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic clock_mode_strap_a,
   input wire logic clock_mode_strap_b,
   input wire logic crystal_or_clock_input,
   input wire logic secondary_clock_input,
   input wire logic deep_idle_instruction,
   output logic machine_clock_output,
   output logic machine_cycle,
   output logic clock_locked,
   output logic oscillator_enable,
   output logic test_mode
);
   logic rst_s1;
   logic rst_n;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   ecms_mode_t mode;
   logic mode_valid;
   logic prim_d;
   logic sec_d;
   logic half;
   ecms_state_t state;
   logic [`ECMS_LOCK_CNT_W-1:0] lock_cnt;
   logic [`ECMS_STOP_CNT_W-1:0] stop_cnt;
   ecms_mode_t next_mode;
   logic next_mode_valid;
   logic next_half;
   ecms_state_t next_state;
   logic [`ECMS_LOCK_CNT_W-1:0] next_lock_cnt;
   logic [`ECMS_STOP_CNT_W-1:0] next_stop_cnt;
   logic next_mco;
   logic next_cycle;
   logic next_locked;
   logic prim_rise;
   logic sec_rise;
   logic sec_edge;
   ecms_mode_t strap_mode;

   assign prim_rise = crystal_or_clock_input && !prim_d;
   assign sec_rise = secondary_clock_input && !sec_d;
   assign sec_edge = secondary_clock_input != sec_d;

   always_comb begin
      unique case ({clock_mode_strap_a, clock_mode_strap_b})
         2'b11: strap_mode = ECMS_DIV2;
         2'b10: strap_mode = ECMS_DIV1;
         2'b00: strap_mode = ECMS_DIV2_OSC_OFF;
         2'b01: strap_mode = ECMS_TEST;
      endcase
   end

   always_comb begin
      next_mode = mode;
      next_mode_valid = 1'b1;
      if (!mode_valid) begin
         next_mode = strap_mode;
      end
      next_half = half;
      next_state = state;
      next_lock_cnt = lock_cnt;
      next_stop_cnt = stop_cnt;
      next_mco = machine_clock_output;
      next_cycle = 1'b0;
      next_locked = clock_locked;
      unique case (mode)
         ECMS_DIV2, ECMS_DIV2_OSC_OFF: begin
            // only input edges move state, so a stopped input holds it
            next_locked = mode_valid;
            // stale edge against the reset copy of the pin is ignored
            if (prim_rise && mode_valid) begin
               next_half = !half;
               next_mco = !half;
               next_cycle = !half;
            end
         end
         ECMS_DIV1: begin
            if (sec_edge) begin
               next_stop_cnt = '0;
            end else if (stop_cnt != `ECMS_STOP_CNT_W'(`ECMS_STOP_CYC)) begin
               next_stop_cnt = stop_cnt + 1'b1;
            end
            unique case (state)
               ECMS_ST_IDLE: begin
                  next_locked = 1'b0;
                  next_mco = 1'b0;
                  if (sec_rise && mode_valid) begin
                     next_state = ECMS_ST_LOCK;
                     next_lock_cnt = '0;
                  end
               end
               ECMS_ST_LOCK: begin
                  if (stop_cnt == `ECMS_STOP_CNT_W'(`ECMS_STOP_CYC)) begin
                     next_state = ECMS_ST_IDLE;
                  end else if (sec_rise) begin
                     next_lock_cnt = lock_cnt + 1'b1;
                     if (lock_cnt ==
                         `ECMS_LOCK_CNT_W'(`ECMS_LOCK_MIN_CYC - 1)) begin
                        next_state = ECMS_ST_RUN;
                        next_locked = 1'b1;
                     end
                  end
               end
               ECMS_ST_RUN: begin
                  next_mco = secondary_clock_input;
                  next_cycle = sec_rise;
                  if (stop_cnt == `ECMS_STOP_CNT_W'(`ECMS_STOP_CYC)) begin
                     // stop in or outside deep idle forces relock either way
                     next_state = ECMS_ST_IDLE;
                     next_locked = 1'b0;
                  end
               end
               default: next_state = ECMS_ST_IDLE;
            endcase
         end
         ECMS_TEST: begin
            next_locked = 1'b0;
            next_mco = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode <= ECMS_DIV2;
         mode_valid <= 1'b0;
         prim_d <= 1'b0;
         sec_d <= 1'b0;
         half <= 1'b0;
         state <= ECMS_ST_IDLE;
         lock_cnt <= '0;
         stop_cnt <= '0;
         machine_clock_output <= 1'b0;
         machine_cycle <= 1'b0;
         clock_locked <= 1'b0;
         oscillator_enable <= 1'b0;
         test_mode <= 1'b0;
      end else begin
         mode <= next_mode;
         mode_valid <= next_mode_valid;
         prim_d <= crystal_or_clock_input;
         sec_d <= secondary_clock_input;
         half <= next_half;
         state <= next_state;
         lock_cnt <= next_lock_cnt;
         stop_cnt <= next_stop_cnt;
         machine_clock_output <= next_mco;
         machine_cycle <= next_cycle;
         clock_locked <= next_locked;
         oscillator_enable <= mode_valid && (mode == ECMS_DIV2);
         test_mode <= mode_valid && (mode == ECMS_TEST);
      end
   end

   // helper: secondary rising edges seen while locked is low in lock phase
   logic [`ECMS_LOCK_CNT_W-1:0] mon_edges;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mon_edges <= '0;
      end else if (state != ECMS_ST_LOCK) begin
         mon_edges <= '0;
      end else if (sec_rise) begin
         mon_edges <= mon_edges + 1'b1;
      end
   end

   chk_lock_min_edges: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(clock_locked) && mode == ECMS_DIV1
      |-> $past(mon_edges) == `ECMS_LOCK_CNT_W'(`ECMS_LOCK_MIN_CYC - 1))
      else $error("lock ended at wrong edge count");
   chk_lock_max_edges: assert property (@(posedge clk) disable iff (!rst_n)
      state == ECMS_ST_LOCK
      |-> mon_edges <= `ECMS_LOCK_CNT_W'(`ECMS_LOCK_MAX_CYC))
      else $error("lock phase too long");
   chk_div2_toggle: assert property (@(posedge clk) disable iff (!rst_n)
      mode == ECMS_DIV2 && mode_valid && prim_rise && !half
      |=> machine_clock_output && machine_cycle)
      else $error("halved clock did not rise");
   chk_div2_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (mode == ECMS_DIV2 || mode == ECMS_DIV2_OSC_OFF) && !prim_rise
      |=> $stable(machine_clock_output) && $stable(half))
      else $error("static path changed without input edge");
   chk_div1_follow: assert property (@(posedge clk) disable iff (!rst_n)
      mode == ECMS_DIV1 && state == ECMS_ST_RUN && next_state == ECMS_ST_RUN
      |=> machine_clock_output == $past(secondary_clock_input))
      else $error("one-to-one output not following input");
   chk_stop_relock: assert property (@(posedge clk) disable iff (!rst_n)
      mode == ECMS_DIV1 && state == ECMS_ST_RUN
      && stop_cnt == `ECMS_STOP_CNT_W'(`ECMS_STOP_CYC)
      |=> !clock_locked && state == ECMS_ST_IDLE)
      else $error("stopped input did not force relock");
   chk_mode_div1: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(mode_valid) |-> mode == ECMS_DIV1
      == (clock_mode_strap_a && !clock_mode_strap_b))
      else $error("one-to-one decode wrong");
   chk_mode_div2: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(mode_valid) |-> mode == ECMS_DIV2
      == (clock_mode_strap_a && clock_mode_strap_b))
      else $error("halved decode wrong");
   chk_osc_off: assert property (@(posedge clk) disable iff (!rst_n)
      mode == ECMS_DIV2_OSC_OFF |=> !oscillator_enable)
      else $error("oscillator on with both straps low");
   chk_mode_fixed: assert property (@(posedge clk) disable iff (!rst_n)
      mode_valid |=> $stable(mode))
      else $error("mode changed after capture");

   cov_div1_lock: cover property (@(posedge clk) disable iff (!rst_n)
      mode == ECMS_DIV1 && $rose(clock_locked));
   cov_div1_relock: cover property (@(posedge clk) disable iff (!rst_n)
      mode == ECMS_DIV1 && $fell(clock_locked) && deep_idle_instruction);
   cov_div2_cycle: cover property (@(posedge clk) disable iff (!rst_n)
      mode == ECMS_DIV2 && machine_cycle);
   cov_test_mode: cover property (@(posedge clk) disable iff (!rst_n)
      test_mode);
endmodule : ecms_top
`default_nettype wire

// ===== include/ecms_consts.svh
/*
 Timing counts for the external clock mode select block.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef ECMS_CONSTS_SVH
`define ECMS_CONSTS_SVH
`define ECMS_LOCK_MIN_CYC 256
`define ECMS_LOCK_MAX_CYC 1000
`define ECMS_LOCK_CNT_W 10
`define ECMS_STOP_CYC 64
`define ECMS_STOP_CNT_W 7
`endif

// ===== include/ecms_pkg.sv
/*
 Types for the external clock mode select block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ecms_pkg;
   typedef enum logic [1:0] {
      ECMS_DIV1,
      ECMS_DIV2,
      ECMS_DIV2_OSC_OFF,
      ECMS_TEST
   } ecms_mode_t;
   typedef enum logic [1:0] {
      ECMS_ST_IDLE,
      ECMS_ST_LOCK,
      ECMS_ST_RUN
   } ecms_state_t;
endpackage : ecms_pkg

// ===== testbench/ecms_clk_src.sv
/*
 external clock source model for the clock mode select block.
 assumes run, sel_b and half change shortly after clk edges.
*/
`timescale 1ns/1ps
`default_nettype none
module ecms_clk_src (
   input wire logic clk,
   input wire logic run,
   input wire logic sel_b,
   input wire logic [3:0] half,
   output logic crystal_or_clock_input,
   output logic secondary_clock_input
);
   logic [3:0] cnt = 4'h0;
   logic lvl = 1'b0;
   logic pat = 1'b0;
   always @(posedge clk) begin
      pat <= #2 ~pat;
      if (!run) begin
         cnt <= 4'h0;
         lvl <= #2 1'b0;
      end else if (cnt + 4'h1 >= half) begin
         cnt <= 4'h0;
         lvl <= #2 ~lvl;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
   // idle pin: tied high in one-to-one, floating pattern otherwise
   assign crystal_or_clock_input = sel_b ? 1'b1 : lvl;
   assign secondary_clock_input = sel_b ? lvl : pat;
endmodule : ecms_clk_src
`default_nettype wire

// ===== testbench/external_clock_mode_select_bench.sv
/*
 self-checking bench: counts source rises and machine cycles.
 assumes ecms_top and the source model ecms_clk_src.
*/
`timescale 1ns/1ps
`default_nettype none
module external_clock_mode_select_bench;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic sa = 1'b0;
   logic sb = 1'b0;
   logic idle = 1'b0;
   logic run = 1'b0;
   logic sel_b = 1'b0;
   logic [3:0] half = 4'h3;
   logic xin, sin, mco, mcy, lk, oe, tm, prev;
   int n_mismatch = 0;
   int check_count = 0;
   int rises = 0;
   int pulses = 0;
   int p0, r0, m;
   always #10 clk = ~clk;
   ecms_clk_src src (.clk(clk), .run(run), .sel_b(sel_b), .half(half),
      .crystal_or_clock_input(xin), .secondary_clock_input(sin));
   ecms_top dut (.clk(clk), .arst_n(arst_n), .clock_mode_strap_a(sa),
      .clock_mode_strap_b(sb), .crystal_or_clock_input(xin),
      .secondary_clock_input(sin), .deep_idle_instruction(idle),
      .machine_clock_output(mco), .machine_cycle(mcy),
      .clock_locked(lk), .oscillator_enable(oe), .test_mode(tm));
   // model: rises of the selected input, machine cycles seen
   always @(posedge clk) begin
      prev <= sel_b ? sin : xin;
      if ((sel_b ? sin : xin) && !prev) rises <= rises + 1;
      if (mcy === 1'b1) pulses <= pulses + 1;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
      end
   endtask : check
   task test_done;
      if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done
   // straps only change under reset
   task start(input logic a, input logic b);
      @(posedge clk);
      #2 arst_n = 1'b0;
      run = 1'b0;
      sa = a;
      sb = b;
      sel_b = a & ~b;
      half = 4'h2 + 4'($urandom % 4);
      repeat (3) @(posedge clk);
      #2 arst_n = 1'b1;
      repeat (6) @(posedge clk);
      #2 rises = 0;
      pulses = 0;
   endtask : start
   task wait_rises(input int n);
      int k;
      k = 0;
      while (rises < n && k < 20000) begin
         @(posedge clk);
         k++;
      end
      if (rises < n) begin
         n_mismatch++;
         $display("unexpected at %0t: input rises missing", $time);
         test_done();
      end
   endtask : wait_rises
   task settle;
      repeat (2) @(posedge clk);
      #2;
   endtask : settle
   initial begin
      void'($urandom(81));
      for (m = 0; m < 2; m++) begin
         start(m[0], m[0]);
         check(oe, m[0]);
         check(tm, 0);
         run = 1'b1;
         wait_rises(9);
         settle();
         check(pulses, 5);
         check(mco, 1);
         run = 1'b0;
         repeat (200) @(posedge clk);
         check(pulses, 5);
         check(mco, 1);
         #2 run = 1'b1;
         wait_rises(11);
         settle();
         check(pulses, 6);
         check(mco, 1);
      end
      start(1'b1, 1'b0);
      check(oe, 0);
      run = 1'b1;
      wait_rises(256);
      settle();
      check(lk, 0);
      check(pulses, 0);
      check(mco, 0);
      wait_rises(257);
      settle();
      check(lk, 1);
      p0 = pulses;
      r0 = rises;
      wait_rises(r0 + 20);
      settle();
      check(pulses - p0, 20);
      check(mco, prev);
      idle = 1'b1;
      run = 1'b0;
      repeat (100) @(posedge clk);
      check(lk, 0);
      check(mco, 0);
      #2 run = 1'b1;
      r0 = rises;
      wait_rises(r0 + 1);
      #2 idle = 1'b0;
      wait_rises(r0 + 256);
      settle();
      check(lk, 0);
      wait_rises(r0 + 257);
      settle();
      check(lk, 1);
      start(1'b0, 1'b1);
      check(tm, 1);
      run = 1'b1;
      wait_rises(6);
      settle();
      check(pulses, 0);
      check(mco, 0);
      test_done();
   end
endmodule : external_clock_mode_select_bench
`default_nettype wire
